// *** rfid_ac_cfg.svh ***
// Purpose: Timing counts and widths of the tag anti-collision sequencer.
// Assumes: sys_clk runs at 25 MHz; the recovered carrier is the link clock.
// Notes:   Counts are derived from times in the modules that use them.
`ifndef RFID_AC_CFG_SVH
`define RFID_AC_CFG_SVH

// System clock rate in MHz.
`define SYS_CLK_MHZ      25
// Least carrier silence that is taken as a reader gap, in ns.
`define GAP_MIN_NS       30000
// Width of the silence timer.
`define GAP_IDLE_W       10
// Carrier cycles in one bit period at the divide-by-128 rate.
`define CARRIER_PER_BIT  128
// Bit periods between the end of the first gap and the first frame.
`define START_DELAY_BITS 5
// Width of the start delay counter, in bits; it counts carrier cycles.
`define START_DLY_W      10
// Frame lengths in bits.
`define FRAME_LONG_BITS  128
`define FRAME_SHORT_BITS 96
// Width of the random-number counter.
`define RND_W            8

`endif

// *** rfid_ac_pkg.sv ***
// Purpose: Types shared by the anti-collision sequencer and its gap detector.
// Assumes: rfid_ac_cfg.svh is compiled alongside.
// Notes:   All sys_clk state of each module is held in one packed struct.
`include "rfid_ac_cfg.svh"

package rfid_ac_pkg;

  typedef enum logic [6:0] {
    ST_BLANK     = 7'h01,
    ST_WAIT_GAP1 = 7'h02,
    ST_START_DLY = 7'h04,
    ST_FIRST_TX  = 7'h08,
    ST_SLOT      = 7'h10,
    ST_SLOT_TX   = 7'h20,
    ST_SPARE     = 7'h40
  } ac_state_t;

  typedef struct packed {
    logic                    meta;
    logic                    sync;
    logic                    prev;
    logic [`GAP_IDLE_W-1:0]  idle;
    logic                    gap;
  } gap_det_t;

  typedef struct packed {
    ac_state_t               st;
    logic [2:0]              meta;
    logic [2:0]              sync;
    logic                    prog_prev;
    logic                    locked;
    logic                    osc_run;
    logic [`RND_W-1:0]       rnd;
    logic [`START_DLY_W-1:0] dly;
    logic [6:0]              phase;
    logic [7:0]              bidx;
    logic                    bit_strobe;
    logic                    mod_active;
  } ac_regs_t;

endpackage

// *** carrier_gap_detect.sv ***
// Purpose: Turns the recovered carrier into carrier ticks and gap events.
// Assumes: carrier_clk stops while the reader field is off.
// Notes:   Silence is timed on sys_clk, since the carrier gives no edges then.
`include "rfid_ac_cfg.svh"

module carrier_gap_detect (
  // Clocks and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic carrier_clk,
  // Events in the sys_clk domain
  output logic      carrier_tick,
  output logic      gap_active,
  output logic      gap_start,
  output logic      gap_end
);

  localparam logic [`GAP_IDLE_W-1:0] GAP_CYC =
    `GAP_IDLE_W'((`GAP_MIN_NS * `SYS_CLK_MHZ + 999) / 1000);

  // A toggle per carrier cycle carries each cycle across as an event.
  logic               link_tgl_q;
  rfid_ac_pkg::gap_det_t q;
  rfid_ac_pkg::gap_det_t d;
  logic               edge_seen;
  logic               gap_next;

  always_ff @(posedge carrier_clk or negedge resetn) begin
    if (!resetn) begin
      link_tgl_q <= 1'b0;
    end else begin
      link_tgl_q <= ~link_tgl_q;
    end
  end

  assign edge_seen = q.sync ^ q.prev;

  always_comb begin
    d      = q;
    d.meta = link_tgl_q;
    d.sync = q.meta;
    d.prev = q.sync;
    if (edge_seen) begin
      d.idle = '0;
    end else if (q.idle != GAP_CYC) begin
      d.idle = q.idle + `GAP_IDLE_W'(1);
    end
    gap_next = !edge_seen && (q.gap || (q.idle == GAP_CYC - `GAP_IDLE_W'(1)));
    d.gap    = gap_next;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign carrier_tick = edge_seen;
  assign gap_active   = q.gap;
  assign gap_start    = gap_next && !q.gap;
  assign gap_end      = q.gap && edge_seen;

  chk_gap_timeout: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.idle == GAP_CYC - `GAP_IDLE_W'(1) && !edge_seen && !q.gap) |=> gap_active)
    else $error("Gap not flagged after the silence count.");
  chk_gap_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    (gap_active && carrier_tick) |=> !gap_active ##1 (q.idle <= `GAP_IDLE_W'(1)))
    else $error("Gap not released when the carrier returned.");

endmodule

// *** rfid_ac_seq.sv ***
// Purpose: Gap-driven anti-collision sequencer of a passive read-only tag.
// Assumes: Bit data and modulation are produced outside from bit_index.
// Notes:   Only the divide-by-128 bit period is handled here.
`include "rfid_ac_cfg.svh"

module rfid_ac_seq (
  // Clocks and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             carrier_clk,
  // Configuration levels from the tag
  input  wire logic             array_lock_bit,
  input  wire logic             prog_mode,
  input  wire logic             frame_len_128,
  // Transmit control towards the encoder and modulator
  output logic                  mod_active,
  output logic                  bit_strobe,
  output logic [7:0]            bit_index,
  // Status
  output logic                  locked,
  output logic                  osc_running,
  output logic [`RND_W-1:0]     rnd_count
);

  localparam logic [`START_DLY_W-1:0] START_TICKS =
    `START_DLY_W'(`START_DELAY_BITS * `CARRIER_PER_BIT);
  localparam logic [6:0] PHASE_LAST = 7'(`CARRIER_PER_BIT - 1);

  rfid_ac_pkg::ac_regs_t q;
  rfid_ac_pkg::ac_regs_t d;
  logic                  carrier_tick;
  logic                  gap_active;
  logic                  gap_start;
  logic                  gap_end;
  logic                  prog_exit;
  logic                  tx_adv;
  logic                  bit_wrap;
  logic                  frame_last;
  logic [7:0]            last_idx;

  // saturating decrement
  // Saturating decrement of the random counter.
  function automatic logic [`RND_W-1:0] sat_dec(input logic [`RND_W-1:0] v);
    sat_dec = (v == '0) ? v : v - `RND_W'(1);
  endfunction

  function automatic logic is_tx(input rfid_ac_pkg::ac_state_t s);
    is_tx = (s == rfid_ac_pkg::ST_FIRST_TX) || (s == rfid_ac_pkg::ST_SLOT_TX);
  endfunction

  carrier_gap_detect u_gap (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .carrier_clk  (carrier_clk),
    .carrier_tick (carrier_tick),
    .gap_active   (gap_active),
    .gap_start    (gap_start),
    .gap_end      (gap_end)
  );

  assign last_idx   = q.sync[2] ? 8'(`FRAME_LONG_BITS - 1) : 8'(`FRAME_SHORT_BITS - 1);
  assign prog_exit  = q.prog_prev && !q.sync[1];
  assign tx_adv     = carrier_tick && !gap_active;
  assign bit_wrap   = (q.phase == PHASE_LAST);
  assign frame_last = (q.bidx == last_idx);

  always_comb begin
    d            = q;
    d.meta       = {frame_len_128, prog_mode, array_lock_bit};
    d.sync       = q.meta;
    d.prog_prev  = q.sync[1];
    d.bit_strobe = 1'b0;
    if (q.sync[0] || prog_exit) begin
      d.locked = 1'b1;
    end
    if (q.osc_run) begin
      d.rnd = q.rnd + `RND_W'(1);
    end
    if (gap_start && (q.st == rfid_ac_pkg::ST_START_DLY || q.st == rfid_ac_pkg::ST_FIRST_TX)) begin
      d.osc_run = 1'b0;
    end
    case (q.st)
      rfid_ac_pkg::ST_BLANK: begin
        if (q.locked) begin
          d.st = rfid_ac_pkg::ST_WAIT_GAP1;
        end
      end
      rfid_ac_pkg::ST_WAIT_GAP1: begin
        if (gap_end) begin
          d.st      = rfid_ac_pkg::ST_START_DLY;
          d.osc_run = 1'b1;
          d.rnd     = '0;
          d.dly     = '0;
        end
      end
      rfid_ac_pkg::ST_START_DLY, rfid_ac_pkg::ST_FIRST_TX: begin
        if (gap_end) begin
          d.st    = (q.rnd == '0) ? rfid_ac_pkg::ST_SLOT_TX : rfid_ac_pkg::ST_SLOT;
          d.phase = '0;
          d.bidx  = '0;
          d.bit_strobe = (q.rnd == '0);
        end else if (tx_adv && q.st == rfid_ac_pkg::ST_START_DLY) begin
          if (q.dly == START_TICKS - `START_DLY_W'(1)) begin
            d.st         = rfid_ac_pkg::ST_FIRST_TX;
            d.phase      = '0;
            d.bidx       = '0;
            d.bit_strobe = 1'b1;
          end else begin
            d.dly = q.dly + `START_DLY_W'(1);
          end
        end else if (tx_adv) begin
          if (!bit_wrap) begin
            d.phase = q.phase + 7'h01;
          end else begin
            d.phase      = '0;
            d.bidx       = frame_last ? 8'h00 : q.bidx + 8'h01;
            d.bit_strobe = 1'b1;
          end
        end
      end
      rfid_ac_pkg::ST_SLOT, rfid_ac_pkg::ST_SLOT_TX: begin
        if (gap_end) begin
          d.rnd = sat_dec(q.rnd);
          if (sat_dec(q.rnd) == '0) begin
            d.st         = rfid_ac_pkg::ST_SLOT_TX;
            d.phase      = '0;
            d.bidx       = '0;
            d.bit_strobe = 1'b1;
          end else begin
            d.st = rfid_ac_pkg::ST_SLOT;
          end
        end else if (tx_adv && q.st == rfid_ac_pkg::ST_SLOT_TX) begin
          if (!bit_wrap) begin
            d.phase = q.phase + 7'h01;
          end else if (frame_last) begin
            d.st    = rfid_ac_pkg::ST_SLOT;
            d.phase = '0;
            d.bidx  = '0;
          end else begin
            d.phase      = '0;
            d.bidx       = q.bidx + 8'h01;
            d.bit_strobe = 1'b1;
          end
        end
      end
      default: begin
        d.st = rfid_ac_pkg::ST_BLANK;
      end
    endcase
    d.mod_active = is_tx(d.st) && !gap_active && !gap_start;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q    <= '0;
      q.st <= rfid_ac_pkg::ST_BLANK;
    end else begin
      q <= d;
    end
  end

  assign mod_active  = q.mod_active;
  assign bit_strobe  = q.bit_strobe;
  assign bit_index   = q.bidx;
  assign locked      = q.locked;
  assign osc_running = q.osc_run;
  assign rnd_count   = q.rnd;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  chk_blank_silent: assert property (!q.locked |-> !mod_active)
    else $error("Transmission while unlocked.");
  chk_no_early_tx: assert property (mod_active |-> is_tx(q.st))
    else $error("Modulator active outside a frame state.");
  chk_osc_start: assert property (
    (q.st == rfid_ac_pkg::ST_WAIT_GAP1 && gap_end) |=> osc_running && rnd_count == '0)
    else $error("Oscillator did not start at the first gap end.");
  chk_rnd_counts: assert property (
    (osc_running && !gap_start) |=> rnd_count == $past(rnd_count) + `RND_W'(1))
    else $error("Random counter did not count a running oscillator.");
  chk_start_delay: assert property (
    $rose(q.st == rfid_ac_pkg::ST_FIRST_TX) |-> $past(q.dly) == START_TICKS - `START_DLY_W'(1))
    else $error("First frame did not wait five bit periods.");
  chk_bit_period: assert property (
    (is_tx(q.st) && tx_adv && !gap_end && bit_wrap && !frame_last) |=> bit_strobe && q.phase == '0)
    else $error("Bit did not end after 128 carrier cycles.");
  chk_osc_in_tx: assert property (
    (q.st == rfid_ac_pkg::ST_FIRST_TX && !gap_active) |-> osc_running)
    else $error("Oscillator stopped during the first frame.");
  chk_rnd_freeze: assert property (
    (q.st == rfid_ac_pkg::ST_SLOT && !gap_end) |=> $stable(rnd_count) && !osc_running)
    else $error("Random counter moved between gaps.");
  chk_dec_step: assert property (
    (q.st == rfid_ac_pkg::ST_SLOT && gap_end) |=> rnd_count == sat_dec($past(rnd_count)))
    else $error("Gap did not decrement the counter by one.");
  chk_tx_at_zero: assert property ((q.st == rfid_ac_pkg::ST_SLOT_TX) |-> rnd_count == '0)
    else $error("Slot frame sent with a non-zero counter.");
  chk_lock_sticky: assert property (locked |=> locked)
    else $error("Lock bit cleared after being set.");

  cov_first_frame: cover property ($rose(q.st == rfid_ac_pkg::ST_FIRST_TX));
  cov_slot_frame: cover property ($rose(q.st == rfid_ac_pkg::ST_SLOT_TX));
  cov_decrement: cover property (q.st == rfid_ac_pkg::ST_SLOT && gap_end && rnd_count > `RND_W'(1));
  cov_lock_by_prog: cover property (prog_exit && !q.locked);

endmodule

// *** reader_model.sv ***
// Purpose: Behavioural reader that powers the tag with a carrier and cuts it for gaps.
// Assumes: The carrier period is 80 ns, with a phase unrelated to sys_clk.
// Notes:   While the field is off the carrier stands still at its low level.
module reader_model (
  // Recovered carrier towards the tag
  output logic carrier_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic field_on = 1'b1;

  initial carrier_clk = 1'b0;

  always begin
    #13;
    forever begin
      #40;
      if (field_on) begin
        carrier_clk = ~carrier_clk;
      end else begin
        carrier_clk = 1'b0;
      end
    end
  end

  task send_gap(input int off_ns);
    field_on = 1'b0;
    #(off_ns);
    field_on = 1'b1;
  endtask
endmodule

// *** rfid_ac_seq_bench.sv ***
// Purpose: Self-checking bench of the tag anti-collision sequencer.
// Assumes: reader_model supplies the carrier and the gaps.
// Notes:   Inputs other than carrier_clk change at the falling edge of sys_clk only.
`include "rfid_ac_cfg.svh"

module rfid_ac_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic lock;
    logic prog;
    logic exp;
  } row_t;

  logic                sys_clk        = 1'b0;
  logic                resetn         = 1'b0;
  logic                array_lock_bit = 1'b0;
  logic                prog_mode      = 1'b0;
  logic                frame_len_128  = 1'b0;
  wire                 carrier_clk;
  logic                mod_active;
  logic                bit_strobe;
  logic [7:0]          bit_index;
  logic                locked;
  logic                osc_running;
  logic [`RND_W-1:0]   rnd_count;
  logic [7:0]          prev;
  int                  bad_count = 0;
  int                  cmp_count = 0;
  int                  cycles    = 0;
  int                  n;
  int                  m;
  row_t                rows [3]  = '{'{1'b0, 1'b0, 1'b0}, '{1'b1, 1'b0, 1'b1}, '{1'b0, 1'b1, 1'b1}};

  always #20 sys_clk = ~sys_clk;

  reader_model reader_u (
    .carrier_clk (carrier_clk)
  );

  rfid_ac_seq dut_u (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .carrier_clk    (carrier_clk),
    .array_lock_bit (array_lock_bit),
    .prog_mode      (prog_mode),
    .frame_len_128  (frame_len_128),
    .mod_active     (mod_active),
    .bit_strobe     (bit_strobe),
    .bit_index      (bit_index),
    .locked         (locked),
    .osc_running    (osc_running),
    .rnd_count      (rnd_count)
  );

  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The run should need about 74000 cycles; the ceiling leaves room.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic wait_strobe;
    int k;
    k = 0;
    do begin
      wait_cyc(1);
      k++;
    end while (bit_strobe !== 1'b1 && k < 300);
    n = k;
  endtask

  // Inputs are cleared first so that no level from the previous test survives reset.
  task automatic do_reset;
    wait_cyc(1);
    array_lock_bit = 1'b0;
    prog_mode      = 1'b0;
    frame_len_128  = 1'b0;
    resetn = 1'b0;
    wait_cyc(12);
    resetn = 1'b1;
    wait_cyc(2);
  endtask

  task automatic gap_and_settle;
    reader_u.send_gap(60000);
    wait_cyc(10);
  endtask

  initial begin
    foreach (rows[i]) begin
      do_reset();
      array_lock_bit = rows[i].lock;
      prog_mode = rows[i].prog;
      wait_cyc(8);
      prog_mode = 1'b0;
      wait_cyc(8);
      check(8'(locked), 8'(rows[i].exp));
      gap_and_settle();
      check(8'(osc_running), 8'(rows[i].exp));
      check(8'(mod_active), 8'h00);
      $display("lock row %0d done", i);
    end
    do_reset();
    array_lock_bit = 1'b1;
    wait_cyc(200);
    check(8'(mod_active), 8'h00);
    reader_u.send_gap(60000);
    for (n = 0; osc_running !== 1'b1 && n < 50; n++) wait_cyc(1);
    check(8'(osc_running), 8'h01);
    prev = rnd_count;
    wait_cyc(4);
    check(8'(rnd_count - prev), 8'h04);
    for (n = 0; mod_active !== 1'b1 && n < 1400; n++) wait_cyc(1);
    check(8'(n >= 1270 && n <= 1290), 8'h01);
    check(8'(bit_strobe), 8'h01);
    check(bit_index, 8'h00);
    wait_strobe();
    check(8'(n >= 254 && n <= 258), 8'h01);
    check(bit_index, 8'h01);
    prev = rnd_count;
    wait_cyc(3);
    check(8'(rnd_count - prev), 8'h03);
    reader_u.send_gap(20000);
    wait_cyc(10);
    check(8'(osc_running), 8'h01);
    $display("first frame test done");
    frame_len_128 = 1'b1;
    for (m = 0; m < 140 && bit_index !== 8'h5F; m++) wait_strobe();
    wait_strobe();
    check(bit_index, 8'h60);
    for (m = 0; m < 140 && bit_index !== 8'h7F; m++) wait_strobe();
    wait_strobe();
    check(bit_index, 8'h00);
    frame_len_128 = 1'b0;
    for (m = 0; m < 140 && bit_index !== 8'h5F; m++) wait_strobe();
    wait_strobe();
    check(bit_index, 8'h00);
    $display("frame length test done");
    // Aim the freeze at a small count so the decrement chain stays short.
    for (n = 0; rnd_count !== 8'h14 && n < 300; n++) wait_cyc(1);
    gap_and_settle();
    check(8'(osc_running), 8'h00);
    prev = rnd_count;
    check(8'(mod_active), 8'(prev == 8'h00));
    wait_cyc(20);
    check(rnd_count, prev);
    for (n = 0; n < 16 && prev !== 8'h00; n++) begin
      gap_and_settle();
      prev = prev - 8'h01;
      check(rnd_count, prev);
      check(8'(mod_active), 8'(prev == 8'h00));
    end
    check(rnd_count, 8'h00);
    gap_and_settle();
    check(rnd_count, 8'h00);
    check(8'(mod_active), 8'h01);
    $display("slot test done");
    report_and_stop();
  end
endmodule
